// ==== qps_regs.vh ====
`ifndef QPS_REGS_VH
`define QPS_REGS_VH

// ==========================================================
// Widths
`define QPS_PC_W 13
`define QPS_INSN_W 14
`define QPS_DATA_W 8
`define QPS_DADDR_W 7
`define QPS_JTGT_W 11

// ==========================================================
// Phase codes, one-hot, Q1 in bit 0
`define QPS_PH_W 4
`define QPS_PH_Q1 4'h1
`define QPS_PH_Q2 4'h2
`define QPS_PH_Q3 4'h4
`define QPS_PH_Q4 4'h8

// ==========================================================
// Vectors and memory sizes
`define QPS_RESET_VEC 13'h0000
`define QPS_IRQ_VEC 13'h0004
`define QPS_PROG_WORDS_SMALL 1024
`define QPS_PROG_WORDS_LARGE 2048

// ==========================================================
// Instruction fields
`define QPS_OPC_HI 13
`define QPS_OPC_LO 11
`define QPS_JMP_OPC 3'h5

`endif

// ==== qps_phase_gen.v ====
`include "qps_regs.vh"

// ==========================================================
// Divide-by-four ring giving one-hot Q1..Q4 phases
module qps_phase_gen #(
   parameter PHASES = `QPS_PH_W
) (
   mclk,
   arst_n,
   phase
);
   input wire mclk;
   input wire arst_n;
   output reg [PHASES-1:0] phase;

   // Ring of one-hot bits; never two phases high at once
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= `QPS_PH_Q1;
      end else begin
         phase <= {phase[PHASES-2:0], phase[PHASES-1]};
      end
   end
endmodule // qps_phase_gen

// ==== qps_sequencer.v ====
`include "qps_regs.vh"

// Function
// - Divide input clock by four into non-overlapping phases Q1 to Q4.
// - Program counter increments in Q1, starting each fetch cycle.
// - Fetched word is captured at Q4 into the instruction register.
// - Captured instruction executes over Q2, Q3, Q4 of the next cycle.
// - Operand read from data memory in Q2, result written in Q4.
// - Fetch overlaps execute, giving one instruction per cycle.
// - Program counter changes take two cycles; fetched word is discarded.
// - Program counter is 13 bits, addressing 8K words of 14 bits.
// - Addresses above the implemented 1K or 2K words wrap around.
// - After reset fetching starts at address zero.
// - A taken interrupt loads the interrupt vector into the counter.
module qps_sequencer #(
   parameter PROG_WORDS = `QPS_PROG_WORDS_LARGE,
   parameter [2:0] JMP_OPC = `QPS_JMP_OPC
) (
   mclk,
   arst_n,
   q1_clk,
   q2_clk,
   q3_clk,
   q4_clk,
   prog_addr,
   prog_rd,
   prog_data,
   ir_word,
   ir_valid,
   exec_pc,
   data_addr,
   data_rd,
   data_rdata,
   operand,
   alu_result,
   alu_wr_en,
   alu_pc_load,
   alu_pc_target,
   data_wr,
   data_wdata,
   irq_req,
   irq_ack,
   irq_ret_addr,
   jump_taken
);
   input wire mclk;
   input wire arst_n;
   output wire q1_clk;
   output wire q2_clk;
   output wire q3_clk;
   output wire q4_clk;
   output wire [`QPS_PC_W-1:0] prog_addr;
   output wire prog_rd;
   input wire [`QPS_INSN_W-1:0] prog_data;
   output wire [`QPS_INSN_W-1:0] ir_word;
   output wire ir_valid;
   output wire [`QPS_PC_W-1:0] exec_pc;
   output wire [`QPS_DADDR_W-1:0] data_addr;
   output wire data_rd;
   input wire [`QPS_DATA_W-1:0] data_rdata;
   output wire [`QPS_DATA_W-1:0] operand;
   input wire [`QPS_DATA_W-1:0] alu_result;
   input wire alu_wr_en;
   input wire alu_pc_load;
   input wire [`QPS_PC_W-1:0] alu_pc_target;
   output wire data_wr;
   output wire [`QPS_DATA_W-1:0] data_wdata;
   input wire irq_req;
   output wire irq_ack;
   output wire [`QPS_PC_W-1:0] irq_ret_addr;
   output wire jump_taken;

   // ==========================================================
   // Constants
   // Mask worked out at full width, then cut to the counter width on purpose
   localparam [31:0] ADDR_MASK_FULL = PROG_WORDS - 1;
   localparam [`QPS_PC_W-1:0] ADDR_MASK = ADDR_MASK_FULL[`QPS_PC_W-1:0];
   localparam [`QPS_PC_W-1:0] PC_ONE = 13'h0001;

   // ==========================================================
   // Phase generator
   wire [`QPS_PH_W-1:0] phase;
   wire ph_q1;
   wire ph_q2;
   wire ph_q3;
   wire ph_q4;

   qps_phase_gen #(
      .PHASES(`QPS_PH_W)
   ) u_phase (
      .mclk(mclk),
      .arst_n(arst_n),
      .phase(phase)
   );

   assign ph_q1 = phase[0];
   assign ph_q2 = phase[1];
   assign ph_q3 = phase[2];
   assign ph_q4 = phase[3];

   // Phase outputs come straight from the ring flops
   assign q1_clk = ph_q1;
   assign q2_clk = ph_q2;
   assign q3_clk = ph_q3;
   assign q4_clk = ph_q4;

   // ==========================================================
   // State
   reg [`QPS_PC_W-1:0] pc_q;
   reg [`QPS_PC_W-1:0] pc_d;
   reg [`QPS_PC_W-1:0] fetch_addr_q;
   reg prog_rd_q;
   reg [`QPS_INSN_W-1:0] ir_q;
   reg ir_valid_q;
   reg [`QPS_PC_W-1:0] exec_pc_q;
   reg data_rd_q;
   reg [`QPS_DATA_W-1:0] operand_q;
   reg data_wr_q;
   reg [`QPS_DATA_W-1:0] data_wdata_q;
   reg pcld_q;
   reg [`QPS_PC_W-1:0] pctgt_q;
   reg irq_ack_q;
   reg [`QPS_PC_W-1:0] irq_ret_q;
   reg jump_taken_q;

   // ==========================================================
   // Decode
   wire is_jump;
   wire [`QPS_PC_W-1:0] jump_target;
   wire redirect;
   wire [`QPS_PC_W-1:0] redirect_target;
   wire take_irq;

   // jump_instruction: opcode in the top bits, target in the low bits
   assign is_jump = ir_valid_q && (ir_q[`QPS_OPC_HI:`QPS_OPC_LO] == JMP_OPC);
   // Upper counter bits are cleared, so a jump reaches only the low 2K words
   assign jump_target = {{(`QPS_PC_W-`QPS_JTGT_W){1'b0}}, ir_q[`QPS_JTGT_W-1:0]};

   // Any change of flow, decoded or reported by the execute unit
   assign redirect = is_jump || (ir_valid_q && pcld_q);
   assign redirect_target = is_jump ? jump_target : pctgt_q;

   // Interrupt waits while a branch is retiring so the return address is right
   assign take_irq = irq_req && !redirect;

   // ==========================================================
   // Phase-qualified strobes
   // Each one is true in a single phase, so the flops below pulse once a slot
   wire exec_rd_go;
   wire exec_wr_go;
   wire redirect_now;
   wire irq_now;
   wire flush_now;

   assign exec_rd_go = ph_q1 && ir_valid_q;
   assign exec_wr_go = ph_q3 && ir_valid_q && alu_wr_en && !is_jump;
   assign redirect_now = ph_q4 && redirect;
   assign irq_now = ph_q4 && take_irq;
   assign flush_now = redirect_now || irq_now;

   // ==========================================================
   // Program counter
   always @* begin
      pc_d = pc_q;
      case (phase)
         `QPS_PH_Q1: begin
            pc_d = pc_q + PC_ONE;
         end
         `QPS_PH_Q4: begin
            // Redirect outranks the interrupt; the request is seen again next slot
            if (redirect) begin
               pc_d = redirect_target;
            end else if (take_irq) begin
               pc_d = `QPS_IRQ_VEC;
            end
         end
         default: begin
            pc_d = pc_q;
         end
      endcase
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pc_q <= `QPS_RESET_VEC;
      end else begin
         pc_q <= pc_d;
      end
   end

   // ==========================================================
   // Fetch stage
   // Address is taken from the counter as it increments, so the word
   // fetched in a cycle is the one at the pre-increment value
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_addr_q <= `QPS_RESET_VEC;
         prog_rd_q <= 1'b0;
      end else begin
         if (ph_q1) begin
            fetch_addr_q <= pc_q;
         end
         prog_rd_q <= ph_q1;
      end
   end

   // Upper address bits fold back into the implemented space
   assign prog_addr = fetch_addr_q & ADDR_MASK;
   assign prog_rd = prog_rd_q;

   // ==========================================================
   // Instruction register
   // The word fetched during a redirect is dropped, not executed
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ir_q <= {`QPS_INSN_W{1'b0}};
         ir_valid_q <= 1'b0;
         exec_pc_q <= `QPS_RESET_VEC;
      end else if (ph_q4) begin
         ir_q <= prog_data;
         exec_pc_q <= prog_addr;
         if (flush_now) begin
            ir_valid_q <= 1'b0;
         end else begin
            ir_valid_q <= 1'b1;
         end
      end
   end

   assign ir_word = ir_q;
   assign ir_valid = ir_valid_q;
   assign exec_pc = exec_pc_q;

   // ==========================================================
   // Execute stage: operand read, result write
   assign data_addr = ir_q[`QPS_DADDR_W-1:0];

   // Operand side
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         data_rd_q <= 1'b0;
         operand_q <= {`QPS_DATA_W{1'b0}};
      end else begin
         // Read strobe stands during Q2 only
         data_rd_q <= exec_rd_go;
         if (ph_q2 && data_rd_q) begin
            operand_q <= data_rdata;
         end
      end
   end

   // Result side
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         data_wr_q <= 1'b0;
         data_wdata_q <= {`QPS_DATA_W{1'b0}};
         pcld_q <= 1'b0;
         pctgt_q <= `QPS_RESET_VEC;
      end else begin
         // Result and flow change sampled at the end of Q3
         if (ph_q3) begin
            data_wdata_q <= alu_result;
            pcld_q <= alu_pc_load;
            pctgt_q <= alu_pc_target;
         end
         // Write strobe stands during Q4 only
         data_wr_q <= exec_wr_go;
      end
   end

   assign data_rd = data_rd_q;
   assign operand = operand_q;
   assign data_wr = data_wr_q;
   assign data_wdata = data_wdata_q;

   // ==========================================================
   // Flow-change reporting
   // Pulses stand for the Q1 that follows the redirect
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         jump_taken_q <= 1'b0;
         irq_ack_q <= 1'b0;
      end else begin
         jump_taken_q <= redirect_now;
         irq_ack_q <= irq_now;
      end
   end

   // Return address holds until the next interrupt is taken
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_ret_q <= `QPS_RESET_VEC;
      end else if (irq_now) begin
         // Discarded fetch is where execution resumes afterwards
         irq_ret_q <= fetch_addr_q;
      end
   end

   assign jump_taken = jump_taken_q;
   assign irq_ack = irq_ack_q;
   assign irq_ret_addr = irq_ret_q;

endmodule // qps_sequencer

// ==== qps_sequencer_asserts.sv ====
`include "qps_regs.vh"
// ==========================================================
// Port checker for the sequencer
module qps_seq_asserts #(
   parameter PROG_WORDS = 2048
) (
   input wire mclk,
   input wire arst_n,
   input wire q1_clk,
   input wire q2_clk,
   input wire q3_clk,
   input wire q4_clk,
   input wire [12:0] prog_addr,
   input wire prog_rd,
   input wire [13:0] prog_data,
   input wire [13:0] ir_word,
   input wire ir_valid,
   input wire [12:0] exec_pc,
   input wire data_rd,
   input wire data_wr,
   input wire irq_ack,
   input wire jump_taken
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam [12:0] TOP = PROG_WORDS - 1;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_jmp;
      q4_clk && ir_valid && ir_word[13:11] == `QPS_JMP_OPC;
   endsequence
   sequence s_flush;
      jump_taken && !ir_valid ##1 q2_clk;
   endsequence
   chk_phase_ring: assert property (q1_clk |=> q2_clk ##1 q3_clk ##1 q4_clk ##1 q1_clk)
      else $error("bad phase order");
   chk_phase_hot: assert property ($onehot({q1_clk, q2_clk, q3_clk, q4_clk}))
      else $error("phases overlap");
   chk_fetch_q2: assert property (prog_rd == q2_clk && (q2_clk || $stable(prog_addr)))
      else $error("fetch outside Q2");
   chk_ir_load: assert property (q1_clk && ir_valid |-> ir_word == $past(prog_data))
      else $error("bad capture");
   chk_data_phase: assert property ((data_rd |-> q2_clk && ir_valid) and (data_wr |-> q4_clk && ir_valid))
      else $error("data strobe in wrong phase");
   chk_next_fetch: assert property (q1_clk && ir_valid |=> prog_addr == ((exec_pc + 13'h0001) & TOP))
      else $error("fetch not sequential");
   chk_jump_flush: assert property (s_jmp |=> s_flush ##0 prog_addr == ({2'b00, $past(ir_word[10:0], 2)} & TOP))
      else $error("bad jump");
   chk_addr_wrap: assert property (prog_addr <= TOP && exec_pc <= TOP)
      else $error("address not wrapped");
   chk_reset_zero: assert property (disable iff (1'b0) !arst_n |=> prog_addr == 13'h0000 && q1_clk)
      else $error("bad reset fetch");
   chk_irq_vec: assert property (irq_ack |-> !ir_valid ##1 prog_addr == 13'h0004)
      else $error("bad vector");
endmodule // qps_seq_asserts

bind qps_sequencer qps_seq_asserts #(.PROG_WORDS(PROG_WORDS)) i_chk (.mclk, .arst_n, .q1_clk, .q2_clk, .q3_clk,
   .q4_clk, .prog_addr, .prog_rd, .prog_data, .ir_word, .ir_valid, .exec_pc, .data_rd, .data_wr, .irq_ack,
   .jump_taken);

// ==== qps_prog_mem.sv ====
// ==========================================================
// Program memory model
module qps_prog_mem (
   input wire [12:0] prog_addr,
   output logic [13:0] prog_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] mem [0:8191];
   // Answers at once, so the word settles long before the capture edge
   assign prog_data = mem[prog_addr];
endmodule // qps_prog_mem

// ==== test_quad_phase_fetch_execute_sequencer.sv ====
`include "qps_regs.vh"
// ==========================================================
// Bench with an instruction-level model
module test_quad_phase_fetch_execute_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   localparam PW = 1024;
   logic mclk = 0;
   logic arst_n = 0;
   logic q1_clk, ir_valid, data_rd, data_wr, irq_ack, jump_taken;
   logic alu_wr_en = 0;
   logic alu_pc_load = 0;
   logic irq_req = 0;
   logic [12:0] prog_addr, exec_pc, irq_ret_addr, ea, fpc, er;
   logic [12:0] alu_pc_target = 0;
   logic [13:0] prog_data, ir_word, w;
   logic [7:0] operand, data_wdata;
   logic [6:0] data_addr;
   logic [7:0] data_rdata = 0;
   logic [7:0] alu_result = 0;
   logic [31:0] rnd = 32'h9a34_9e16;
   logic ev, ej, ei, jmp, rd, wr;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   always #25 mclk = ~mclk;
   qps_sequencer #(.PROG_WORDS(PW)) i_dut (.mclk, .arst_n, .q1_clk, .q2_clk(), .q3_clk(), .q4_clk(), .prog_addr,
      .prog_rd(), .prog_data, .ir_word, .ir_valid, .exec_pc, .data_addr, .data_rd, .data_rdata, .operand,
      .alu_result, .alu_wr_en, .alu_pc_load, .alu_pc_target, .data_wr, .data_wdata, .irq_req, .irq_ack,
      .irq_ret_addr, .jump_taken);
   qps_prog_mem i_mem (.prog_addr, .prog_data);
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Two runs of 150 slots at four cycles each, with ample margin
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic do_reset;
      arst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      {ev, ej, ei} = 3'h0;
      fpc = 13'h0000;
      ea = 13'h0000;
   endtask
   task automatic run(input int n);
      repeat (n) begin
         // Inputs set at the slot's opening edge are settled by this negedge
         @(negedge mclk);
         w = i_mem.mem[ea];
         jmp = ev && w[13:11] == `QPS_JMP_OPC;
         rd = jmp || (ev && alu_pc_load);
         wr = ev && alu_wr_en && !jmp;
         chk("q1", q1_clk, 1);
         chk("valid", ir_valid, ev);
         chk("jump", jump_taken, ej);
         chk("ack", irq_ack, ei);
         if (ei) chk("ret", irq_ret_addr, er);
         if (ev) chk("pc", exec_pc, ea);
         if (ev) chk("ir", ir_word, w);
         if (ev) chk("daddr", data_addr, w[6:0]);
         @(negedge mclk);
         chk("fetch", prog_addr, fpc & 13'(PW - 1));
         chk("rd", data_rd, ev);
         @(negedge mclk);
         if (ev) chk("opnd", operand, data_rdata);
         @(negedge mclk);
         chk("wr", data_wr, wr);
         if (wr) chk("wdata", data_wdata, alu_result);
         ej = rd;
         ei = !rd && irq_req;
         er = fpc;
         ev = !rd && !irq_req;
         ea = fpc & 13'(PW - 1);
         fpc = rd ? (jmp ? {2'b00, w[10:0]} : alu_pc_target) : (irq_req ? 13'h0004 : fpc + 13'h0001);
         @(posedge mclk);
         rnd = lfsr(rnd);
         data_rdata <= rnd[7:0];
         alu_result <= rnd[15:8];
         alu_wr_en <= rnd[16];
         irq_req <= rnd[19:17] == 3'h0;
         alu_pc_target <= rnd[31:19];
         alu_pc_load <= ev && i_mem.mem[ea][13:11] != `QPS_JMP_OPC && rnd[23:21] == 3'h0;
      end
   endtask
   initial begin
      for (int i = 0; i < PW; i++) begin
         rnd = lfsr(rnd);
         i_mem.mem[i] = rnd[13:0];
      end
      // Jump past the top, then a jump right after it
      i_mem.mem[0] = 14'h2fff;
      i_mem.mem[PW - 1] = 14'h2801;
      do_reset();
      run(150);
      do_reset();
      run(150);
      report_and_stop();
   end
endmodule // test_quad_phase_fetch_execute_sequencer
